/* rtl/cfs_regs.svh */
// Register map, field positions, reset values and timing counts of the supervisor
`ifndef CFS_REGS_SVH
`define CFS_REGS_SVH

// ----------------------------------------------------------------------------
// Channel numbering
// ----------------------------------------------------------------------------
`define CFS_NUM_CH 6
`define CFS_CH_BOOST 0
`define CFS_CH_MAIN 1
`define CFS_CH_STEPDOWN 2
`define CFS_CH_AUX1 3

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define CFS_ADDR_CTRL 32'h0000_0000
`define CFS_ADDR_STATUS 32'h0000_0004
`define CFS_ADDR_FAULT 32'h0000_0008

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CFS_CTRL_EN_MASK 6'h3e
`define CFS_CTRL_RESET 6'h00
`define CFS_ST_RUN_LSB 0
`define CFS_ST_LATCHED 8
`define CFS_ST_UV_RETRY 9
`define CFS_ST_REF_EN 10
`define CFS_ST_THERMAL 11
`define CFS_ST_PIN_LSB 12

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CFS_CLK_MHZ 200
`define CFS_ONESHOT_NS 200
`define CFS_RAMP_OSC 4096
`define CFS_SD_RAMP_OSC 2048
`define CFS_AUX_DELAY_OSC 1024
`define CFS_FAULT_OSC 100000

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define CFS_RESP_OKAY 2'h0
`define CFS_RESP_DECERR 2'h3

`endif

/* rtl/cfs_pkg.sv */
// Types shared by the sequencing and fault supervisor
package cfs_pkg;
  `include "cfs_regs.svh"

  // Per-channel sequencing state
  typedef enum logic [1:0] {
    CFS_CH_OFF,
    CFS_CH_WAIT,
    CFS_CH_RAMP,
    CFS_CH_RUN
  } cfs_ch_state_t;

  // Whole state of the supervisor
  typedef struct packed {
    cfs_ch_state_t [5:0] ch;
    logic [5:0][12:0] ramp_cnt;
    logic [5:0][16:0] flt_cnt;
    logic [5:0][11:0] soft_ref;
    logic [5:0] ch_active;
    logic [10:0] aux_wait;
    logic latched;
    logic [5:0] latch_cause;
    logic uv_retry;
    logic [5:0] os_cnt;
    logic osc_tick;
    logic discharge;
    logic ref_enable;
    logic startup_drive;
    logic core_good_oe;
    logic aux_good_oe;
    logic fls_oe;
    logic [5:0] ctrl_en;
    logic aw_full;
    logic [31:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cfs_state_t;
endpackage

/* rtl/cfs_supervisor.sv */
// Converter sequencing and fault supervisor with AXI4-Lite register slave
// Operation
// - Core good low after step-down ramp
// - Core good released on shutdown, latch, thermal
// - First aux good low after its ramp
// - First aux good released on shutdown, latch, thermal
// - Load-switch fault low normally, released on latch
// - Reference ramps full scale over 4096 cycles
// - Step-down ramp takes 2048 cycles
// - Boost channel has no counted ramp
// - 100,000 cycles out of regulation latches off
// - Latch cleared by boost enable cycling
// - Fault detection masked during soft-start
// - Boost rail undervoltage shuts all immediately
// - Boost keeps retrying after undervoltage
// - Boost restart refaults if interval expires
// - Reference enabled by enable and good rail
// - Oscillator cycle with 200ns discharge one-shot
// - Channels and timing oscillator held off while boost rail low
// - Startup oscillator while unlatched until rail good
// - Channels need enable and boost regulation
// - Auxiliaries wait 1024 cycles after boost
`timescale 1ns/1ps
`include "cfs_regs.svh"

module cfs_supervisor
  import cfs_pkg::*;
#(
  parameter int unsigned FAULT_OSC_CYCLES = `CFS_FAULT_OSC
) (
  input logic aclk,
  input logic aresetn,
  // Analogue and pin side
  input logic boost_enable_in,
  input logic boost_rail_ok,
  input logic thermal_limit,
  input logic timing_rc_at_ref,
  input logic [5:0] chan_in_reg,
  input logic core_good_n_i,
  output logic core_good_n_o,
  output logic core_good_n_oe,
  input logic first_aux_good_n_i,
  output logic first_aux_good_n_o,
  output logic first_aux_good_n_oe,
  input logic fault_load_switch_n_i,
  output logic fault_load_switch_n_o,
  output logic fault_load_switch_n_oe,
  output logic timing_rc_discharge,
  output logic ref_enable,
  output logic boost_startup_drive,
  output logic [5:0] chan_active,
  output logic [5:0][11:0] soft_ref,
  // AXI4-Lite slave
  input logic [31:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [31:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready
);

  // --------------------------------------------------------------------------
  // Derived counts
  // --------------------------------------------------------------------------
  // One-shot length rounded up to whole clock cycles
  localparam int ONESHOT_CYC_I = (`CFS_ONESHOT_NS * `CFS_CLK_MHZ + 999) / 1000;
  localparam logic [5:0] ONESHOT_CYC = 6'(ONESHOT_CYC_I);
  // Last count of the persistent fault timer
  localparam logic [16:0] FLT_LAST = 17'(FAULT_OSC_CYCLES - 1);
  // Boost start interval and auxiliary delay
  localparam logic [12:0] RAMP_LAST = 13'(`CFS_RAMP_OSC - 1);
  localparam logic [10:0] AUX_DELAY = 11'(`CFS_AUX_DELAY_OSC);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Last oscillator count of a channel's soft-start ramp
  function automatic logic [12:0] ramp_last(input int idx);
    if (idx == `CFS_CH_STEPDOWN) begin
      // Step-down ramps in half the time
      ramp_last = 13'(`CFS_SD_RAMP_OSC - 1);
    end else begin
      // Every other ramped channel
      ramp_last = RAMP_LAST;
    end
  endfunction

  // Reference level of a channel from its state and ramp count
  function automatic logic [11:0] ref_level(input int idx, input cfs_ch_state_t st,
                                            input logic [12:0] cnt);
    // Off or waiting: zero reference
    ref_level = 12'h000;
    if (st == CFS_CH_RUN) begin
      // Regulating: full-scale reference
      ref_level = 12'hfff;
    end else if (st == CFS_CH_RAMP) begin
      if (idx == `CFS_CH_BOOST) begin
        // Boost is never ramped
        ref_level = 12'hfff;
      end else if (idx == `CFS_CH_STEPDOWN) begin
        // Twice the slope of the others
        ref_level = {cnt[10:0], 1'b0};
      end else begin
        // One step per oscillator cycle
        ref_level = cnt[11:0];
      end
    end
  endfunction

  // Register address decode
  function automatic logic is_mapped(input logic [31:0] addr);
    is_mapped = (addr == `CFS_ADDR_CTRL) || (addr == `CFS_ADDR_STATUS) ||
                (addr == `CFS_ADDR_FAULT);
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  cfs_state_t s; // Registered state
  cfs_state_t next_s; // Next state
  logic [31:0] status_word; // Live status view

  // Status word assembly
  always_comb begin
    status_word = 32'h0000_0000;
    for (int i = 0; i < `CFS_NUM_CH; i++) begin
      status_word[`CFS_ST_RUN_LSB + i] = (s.ch[i] == CFS_CH_RUN);
    end
    status_word[`CFS_ST_LATCHED] = s.latched;
    status_word[`CFS_ST_UV_RETRY] = s.uv_retry;
    status_word[`CFS_ST_REF_EN] = s.ref_enable;
    status_word[`CFS_ST_THERMAL] = thermal_limit;
    status_word[`CFS_ST_PIN_LSB] = core_good_n_i;
    status_word[`CFS_ST_PIN_LSB + 1] = first_aux_good_n_i;
    status_word[`CFS_ST_PIN_LSB + 2] = fault_load_switch_n_i;
  end

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic hold;
    logic en_i;
    logic tick;
    hold = 1'b0;
    en_i = 1'b0;
    tick = s.osc_tick;
    next_s = s;
    next_s.osc_tick = 1'b0;

    // Reference and startup oscillator control
    next_s.ref_enable = boost_enable_in & boost_rail_ok;
    next_s.startup_drive = boost_enable_in & ~boost_rail_ok & ~s.latched;

    // Timing oscillator: comparator trip starts the discharge one-shot
    if (s.os_cnt != 6'h00) begin
      // One-shot running: count it down
      next_s.os_cnt = s.os_cnt - 6'h01;
    end else if (s.ref_enable && timing_rc_at_ref) begin
      // Capacitor at reference: new cycle
      next_s.os_cnt = ONESHOT_CYC;
      next_s.osc_tick = 1'b1;
    end
    next_s.discharge = (next_s.os_cnt != 6'h00);

    // Latch released by dropping the boost enable
    if (!boost_enable_in) begin
      next_s.latched = 1'b0;
      next_s.latch_cause = 6'h00;
    end

    // Everything held off on low rail, latch or boost disabled
    hold = ~boost_rail_ok | s.latched | ~boost_enable_in;

    // Undervoltage retry flag
    if (!boost_rail_ok && s.ch[`CFS_CH_BOOST] != CFS_CH_OFF) begin
      // Rail lost while the boost was working
      next_s.uv_retry = 1'b1;
    end else if (s.ch[`CFS_CH_BOOST] == CFS_CH_RUN || !boost_enable_in) begin
      // Boost regulating again, or switched off
      next_s.uv_retry = 1'b0;
    end

    // Auxiliary start delay after boost regulation
    if (hold || s.ch[`CFS_CH_BOOST] != CFS_CH_RUN) begin
      // Delay restarts whenever the boost is not regulating
      next_s.aux_wait = 11'h000;
    end else if (tick && s.aux_wait != AUX_DELAY) begin
      // One step per oscillator cycle, held at the end
      next_s.aux_wait = s.aux_wait + 11'h001;
    end

    // Per-channel sequencing
    for (int i = 0; i < `CFS_NUM_CH; i++) begin
      en_i = (i == `CFS_CH_BOOST) ? boost_enable_in : s.ctrl_en[i];
      if (hold || !en_i) begin
        // Shut down at once
        next_s.ch[i] = CFS_CH_OFF;
        next_s.ramp_cnt[i] = 13'h0000;
        next_s.flt_cnt[i] = 17'h0_0000;
      end else begin
        unique case (s.ch[i])
          CFS_CH_OFF: begin
            // Boost goes straight to its start interval
            next_s.ch[i] = (i == `CFS_CH_BOOST) ? CFS_CH_RAMP : CFS_CH_WAIT;
            next_s.ramp_cnt[i] = 13'h0000;
          end
          CFS_CH_WAIT: begin
            // Wait for boost regulation and the auxiliary delay
            if (s.ch[`CFS_CH_BOOST] == CFS_CH_RUN &&
                (i < `CFS_CH_AUX1 || s.aux_wait == AUX_DELAY)) begin
              next_s.ch[i] = CFS_CH_RAMP;
            end
          end
          CFS_CH_RAMP: begin
            // Fault counter idle during soft-start
            next_s.flt_cnt[i] = 17'h0_0000;
            if (i == `CFS_CH_BOOST) begin
              if (chan_in_reg[i]) begin
                // Rail regulating: hand over to the loop
                next_s.ch[i] = CFS_CH_RUN;
                next_s.ramp_cnt[i] = 13'h0000;
              end else if (tick) begin
                if (s.ramp_cnt[i] == RAMP_LAST) begin
                  // Interval expired unregulated: fault again, retry
                  next_s.ramp_cnt[i] = 13'h0000;
                  next_s.uv_retry = 1'b1;
                end else begin
                  next_s.ramp_cnt[i] = s.ramp_cnt[i] + 13'h0001;
                end
              end
            end else if (tick) begin
              if (s.ramp_cnt[i] == ramp_last(i)) begin
                // Ramp done: regulate
                next_s.ch[i] = CFS_CH_RUN;
              end else begin
                next_s.ramp_cnt[i] = s.ramp_cnt[i] + 13'h0001;
              end
            end
          end
          CFS_CH_RUN: begin
            // Persistent out-of-regulation timer
            if (chan_in_reg[i]) begin
              // Back in regulation: start over
              next_s.flt_cnt[i] = 17'h0_0000;
            end else if (tick) begin
              if (s.flt_cnt[i] == FLT_LAST) begin
                // Fault persisted: latch every channel off
                next_s.latched = 1'b1;
                next_s.latch_cause[i] = 1'b1;
              end else begin
                next_s.flt_cnt[i] = s.flt_cnt[i] + 17'h0_0001;
              end
            end
          end
        endcase
      end
      // Reference level and activity per channel
      next_s.soft_ref[i] = ref_level(i, next_s.ch[i], next_s.ramp_cnt[i]);
      next_s.ch_active[i] = (next_s.ch[i] == CFS_CH_RAMP) || (next_s.ch[i] == CFS_CH_RUN);
    end

    // Open-drain status outputs
    next_s.core_good_oe = (next_s.ch[`CFS_CH_STEPDOWN] == CFS_CH_RUN) &&
                          !next_s.latched && !thermal_limit;
    next_s.aux_good_oe = (next_s.ch[`CFS_CH_AUX1] == CFS_CH_RUN) &&
                         !next_s.latched && !thermal_limit;
    next_s.fls_oe = !next_s.latched;

    // ------------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------------
    // Capture address and data independently
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    // Response retires on bready
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    // Perform the write once both halves are held
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = is_mapped(s.aw_addr) ? `CFS_RESP_OKAY : `CFS_RESP_DECERR;
      // Only the low byte lane carries the enables
      if (s.aw_addr == `CFS_ADDR_CTRL && s.w_strb[0]) begin
        next_s.ctrl_en = s.w_data[5:0] & `CFS_CTRL_EN_MASK;
      end
    end
    next_s.awready = !next_s.aw_full && !next_s.bvalid;
    next_s.wready = !next_s.w_full && !next_s.bvalid;

    // ------------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------------
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = is_mapped(s_axi_araddr) ? `CFS_RESP_OKAY : `CFS_RESP_DECERR;
      if (s_axi_araddr == `CFS_ADDR_CTRL) begin
        // Enables, boost bit always zero
        next_s.rdata = {26'h000_0000, s.ctrl_en};
      end else if (s_axi_araddr == `CFS_ADDR_STATUS) begin
        // Live status snapshot
        next_s.rdata = status_word;
      end else if (s_axi_araddr == `CFS_ADDR_FAULT) begin
        // Channels that caused the latch
        next_s.rdata = {26'h000_0000, s.latch_cause};
      end else begin
        // Unmapped reads return zero
        next_s.rdata = 32'h0000_0000;
      end
    end
    next_s.arready = !next_s.rvalid;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // All channels off, all pins released
      s <= '0;
      s.ctrl_en <= `CFS_CTRL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Open-drain pins only ever pull low
  assign core_good_n_o = 1'b0;
  assign core_good_n_oe = s.core_good_oe;
  assign first_aux_good_n_o = 1'b0;
  assign first_aux_good_n_oe = s.aux_good_oe;
  assign fault_load_switch_n_o = 1'b0;
  assign fault_load_switch_n_oe = s.fls_oe;
  assign timing_rc_discharge = s.discharge;
  assign ref_enable = s.ref_enable;
  assign boost_startup_drive = s.startup_drive;
  assign chan_active = s.ch_active;
  assign soft_ref = s.soft_ref;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;

endmodule

/* testbench/cfs_supervisor_properties.sv */
// Concurrent checks on the supervisor pins
`timescale 1ns/1ps
module cfs_supervisor_props
  import cfs_pkg::*;
#(
  parameter int unsigned FAULT_OSC_CYCLES = 20
) (
  input logic aclk,
  input logic aresetn,
  input logic boost_enable_in,
  input logic boost_rail_ok,
  input logic thermal_limit,
  input logic timing_rc_at_ref,
  input logic core_good_n_o,
  input logic core_good_n_oe,
  input logic first_aux_good_n_oe,
  input logic fault_load_switch_n_oe,
  input logic timing_rc_discharge,
  input logic ref_enable,
  input logic boost_startup_drive,
  input logic [5:0] chan_active,
  input logic [5:0][11:0] soft_ref
);
  // Length of the current discharge pulse
  logic [5:0] shot_cnt;
  always_ff @(posedge aclk) begin
    shot_cnt <= timing_rc_discharge ? shot_cnt + 6'h1 : 6'h0;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // Status pins
  // ----
  a_core_od: assert property (core_good_n_oe |->
    !core_good_n_o && soft_ref[2] == 12'hfff)
    else $error("core good before step-down regulates");
  a_core_thermal: assert property (thermal_limit |=> !core_good_n_oe)
    else $error("core good held in thermal limit");
  a_aux_thermal: assert property (thermal_limit |=> !first_aux_good_n_oe)
    else $error("aux good held in thermal limit");
  a_latch_off: assert property ($fell(fault_load_switch_n_oe) |-> ##[0:1] chan_active == 6'h00)
    else $error("load switch fault without shutdown");
  // ----
  // Rail and sequencing
  // ----
  a_uv_off: assert property (!boost_rail_ok |-> ##[1:2] chan_active == 6'h00)
    else $error("channels alive on low rail");
  a_ref_follow: assert property ($past(aresetn) |->
    ref_enable == ($past(boost_enable_in) && $past(boost_rail_ok)))
    else $error("reference enable wrong");
  a_startup_osc: assert property (boost_startup_drive |->
    !$past(boost_rail_ok) && $past(boost_enable_in))
    else $error("startup drive with good rail");
  a_boost_soft: assert property ($rose(chan_active[0]) |-> ##[0:1] soft_ref[0] == 12'hfff)
    else $error("boost reference ramped");
  // ----
  // Oscillator
  // ----
  a_shot_start: assert property ($rose(timing_rc_discharge) |-> $past(timing_rc_at_ref))
    else $error("discharge without comparator");
  a_shot_long: assert property (timing_rc_discharge |-> shot_cnt < 6'h28)
    else $error("discharge too long");
  a_shot_len: assert property ($fell(timing_rc_discharge) && ref_enable |->
    shot_cnt == 6'h28)
    else $error("discharge too short");
endmodule

bind cfs_supervisor cfs_supervisor_props #(.FAULT_OSC_CYCLES(FAULT_OSC_CYCLES)) u_props (.*);

/* testbench/cfs_stage_model.sv */
// Power stage, timing capacitor and pull-up model
`timescale 1ns/1ps
module cfs_stage_model #(
  parameter int CHARGE = 1
) (
  input logic aclk,
  input logic timing_rc_discharge,
  input logic ref_enable,
  input logic [5:0] chan_active,
  input logic [5:0][11:0] soft_ref,
  input logic [5:0] force_fault,
  input logic core_good_n_oe,
  input logic first_aux_good_n_oe,
  input logic fault_load_switch_n_oe,
  output logic timing_rc_at_ref,
  output logic [5:0] chan_in_reg,
  output logic core_good_n_i,
  output logic first_aux_good_n_i,
  output logic fault_load_switch_n_i
);
  int chg = 0;
  // Capacitor charges after each discharge
  always @(posedge aclk) begin
    if (timing_rc_discharge || !ref_enable) begin
      chg <= 0;
    end else if (!timing_rc_at_ref) begin
      chg <= chg + 1;
    end
  end
  assign timing_rc_at_ref = (chg == CHARGE);
  // Output regulates once its reference is full
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      chan_in_reg[i] = chan_active[i] && soft_ref[i] == 12'hfff && !force_fault[i];
    end
  end
  // Pull-ups on the open-drain pins
  assign core_good_n_i = !core_good_n_oe;
  assign first_aux_good_n_i = !first_aux_good_n_oe;
  assign fault_load_switch_n_i = !fault_load_switch_n_oe;
endmodule

/* testbench/cfs_supervisor_tb_top.sv */
// Self-checking bench for the sequencing supervisor
`timescale 1ns/1ps
module cfs_supervisor_tb_top;
  import cfs_pkg::*;
  logic aclk = 0, aresetn = 0, boost_enable_in = 0, boost_rail_ok = 0, thermal_limit = 0;
  logic timing_rc_at_ref, core_good_n_i, core_good_n_o, core_good_n_oe;
  logic first_aux_good_n_i, first_aux_good_n_o, first_aux_good_n_oe;
  logic fault_load_switch_n_i, fault_load_switch_n_o, fault_load_switch_n_oe;
  logic timing_rc_discharge, ref_enable, boost_startup_drive;
  logic [5:0] chan_in_reg, chan_active, force_fault = 0;
  logic [5:0][11:0] soft_ref;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd, rnd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, dprev = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int miscompares = 0, checks_done = 0, ticks = 0, ctrl_m = 0, t0, k;
  cfs_supervisor #(.FAULT_OSC_CYCLES(20)) uut (.*);
  cfs_stage_model u_stage (.*);
  always #2.5 aclk = ~aclk;
  // Oscillator tick counter
  always @(posedge aclk) begin
    dprev <= timing_rc_discharge;
    if (timing_rc_discharge && !dprev) ticks <= ticks + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Bus write, waits for the response
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Let an edge pass before the next request
    @(posedge aclk);
  endtask
  // Bus read, waits for the data
  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    // Let an edge pass before the next request
    @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    cyc(96000);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    rnd = $urandom(41);
    cyc(8);
    chk({core_good_n_oe, first_aux_good_n_oe, fault_load_switch_n_oe}, 3'h0, "reset pins");
    aresetn <= 1'b1;
    boost_enable_in <= 1'b1;
    cyc(4);
    chk({ref_enable, boost_startup_drive, chan_active}, 8'h40, "rail low");
    chk(fault_load_switch_n_oe, 1'h1, "normal load switch");
    chk({core_good_n_o, first_aux_good_n_o, fault_load_switch_n_o}, 3'h0, "pins pull low");
    axi_rd(32'h0, rd, rsp);
    chk(rd, ctrl_m, "ctrl reset");
    rnd = $urandom;
    axi_wr(32'h0, rnd, rsp);
    ctrl_m = rnd & 32'h3e;
    axi_rd(32'h0, rd, rsp);
    chk(rd, ctrl_m, "ctrl readback");
    axi_wr(32'h100 | (rnd & 32'hf0), rnd, rsp);
    chk(rsp, 2'h3, "unmapped write");
    axi_rd(32'h100 | (rnd & 32'hf0), rd, rsp);
    chk(rd, 32'h0000_0000, "unmapped data");
    chk(rsp, 2'h3, "unmapped read");
    axi_wr(32'h4, rnd, rsp);
    chk(rsp, 2'h0, "status write");
    axi_wr(32'h0, 32'hc, rsp);
    boost_rail_ok <= 1'b1;
    cyc(3);
    chk({ref_enable, boost_startup_drive, chan_active[0]}, 3'h5, "boost up");
    chk(soft_ref[0], 12'hfff, "boost ref");
    k = 0;
    while (!chan_active[2] && k < 100) begin
      cyc(1);
      k++;
    end
    t0 = ticks;
    chk(chan_active[2], 1'h1, "step-down start");
    chk(chan_active[3], 1'h0, "aux waits");
    while (!core_good_n_oe && k < 120000) begin
      cyc(1);
      k++;
    end
    chk((ticks - t0) inside {[2047:2049]}, 1'h1, "step-down ramp");
    chk({soft_ref[2], fault_load_switch_n_oe}, 13'h1fff, "ramp masked");
    chk({chan_active[3], first_aux_good_n_oe}, 2'h2, "aux ramping");
    thermal_limit <= 1'b1;
    cyc(2);
    chk(core_good_n_oe, 1'h0, "thermal");
    thermal_limit <= 1'b0;
    cyc(2);
    chk(core_good_n_oe, 1'h1, "good again");
    force_fault[2] <= 1'b1;
    t0 = ticks;
    while (ticks < t0 + 12) cyc(1);
    force_fault[2] <= 1'b0;
    cyc(3);
    chk(fault_load_switch_n_oe, 1'h1, "short fault");
    t0 = ticks;
    force_fault[2] <= 1'b1;
    k = 0;
    while (fault_load_switch_n_oe && k < 5000) begin
      cyc(1);
      k++;
    end
    chk((ticks - t0) inside {[19:21]}, 1'h1, "fault delay");
    cyc(2);
    chk({chan_active, core_good_n_oe}, 7'h0, "latched off");
    axi_rd(32'h8, rd, rsp);
    chk(rd, 32'h4, "fault cause");
    force_fault[2] <= 1'b0;
    cyc(20);
    chk(fault_load_switch_n_oe, 1'h0, "latch holds");
    boost_enable_in <= 1'b0;
    cyc(2);
    boost_enable_in <= 1'b1;
    cyc(6);
    chk({chan_active[0], fault_load_switch_n_oe}, 2'h3, "latch cleared");
    boost_rail_ok <= 1'b0;
    cyc(2);
    chk({chan_active, fault_load_switch_n_oe}, 7'h1, "undervoltage");
    axi_rd(32'h4, rd, rsp);
    chk(rd, 32'h0000_3200, "retry flag and pins");
    tally_and_finish;
  end
endmodule
